// ===== rtl/pfwr_pkg.sv
// Package for the programmable frequency / watchdog recovery control block.
// Assumes a 10 MHz system clock; shared by the top and its tick module.
package pfwr_pkg;

  // ==========================================================================
  // Clock rate and watchdog tick timing
  localparam longint CLK_HZ          = 10000000;
  localparam int     TICK_SHORT_MS   = 150;      // 150 ms step
  localparam int     TICK_LONG_MS    = 2500;     // 2.5 sec step
  localparam longint TICK_SHORT_CYC  = CLK_HZ * TICK_SHORT_MS / 1000;
  localparam longint TICK_LONG_CYC   = CLK_HZ * TICK_LONG_MS / 1000;
  localparam int     RST_PULSE_CYC   = 16;       // System reset pulse width
  localparam int     TICK_W          = 32;

  // ==========================================================================
  // Field widths and reset values
  localparam int        CODE_W         = 5;
  localparam int        N_W            = 8;
  localparam int        M_W            = 7;
  localparam int        WD_W           = 5;
  localparam int        NM_OFFSET      = 3;      // Fcpu = G*(N+3)/(M+3)
  localparam logic      PROG_EN_RST    = 1'b0;
  localparam logic      OVERRIDE_RST   = 1'b0;
  localparam logic [4:0] CODE_RST      = 5'h00;
  localparam logic [7:0] N_RST         = 8'h00;
  localparam logic [6:0] M_RST         = 7'h00;

  // ==========================================================================
  // Frequency source in use
  typedef enum logic [1:0]
  {
    PFWR_SRC_STRAP = 2'b00,
    PFWR_SRC_SOFT  = 2'b01,
    PFWR_SRC_NM    = 2'b10
  } pfwr_src_t;

  // Watchdog state
  typedef enum logic [1:0]
  {
    PFWR_WD_IDLE  = 2'b00,
    PFWR_WD_RUN   = 2'b01,
    PFWR_WD_TRIP  = 2'b10
  } pfwr_wd_t;

  // N/M pair
  typedef struct packed
  {
    logic [N_W-1:0] n;
    logic [M_W-1:0] m;
  } pfwr_nm_t;

  // Frequency selection presented to the PLL
  typedef struct packed
  {
    pfwr_src_t       src;
    logic [CODE_W-1:0] ratio_code;  // Gear constant and output ratio code
    pfwr_nm_t        nm;
    logic            recovery;
  } pfwr_freq_t;

endpackage

// ===== rtl/pfwr_tick.sv
// Watchdog time base: one-cycle tick every 150 ms or 2.5 sec.
// Assumes a free-running system clock; restart realigns the phase.
`timescale 1ns/1ps
module pfwr_tick
#(
  parameter longint SHORT_CYC = pfwr_pkg::TICK_SHORT_CYC,
  parameter longint LONG_CYC  = pfwr_pkg::TICK_LONG_CYC
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic restart,
  input  wire logic long_scale,
  // Tick out
  output logic      tick
);
  import pfwr_pkg::*;

  logic [TICK_W-1:0] cnt_reg;
  logic [TICK_W-1:0] cnt_next;
  wire  [TICK_W-1:0] limit;
  wire               at_end;

  // Step length picked by the prescaler bit
  assign limit  = long_scale ? TICK_W'(LONG_CYC - 1) : TICK_W'(SHORT_CYC - 1);
  assign at_end = (cnt_reg >= limit);
  assign cnt_next = (restart || at_end) ? '0 : cnt_reg + 1'b1;
  assign tick   = at_end && !restart;

  // Free count; compare by >= so a scale change never overruns
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule

// ===== rtl/pfwr_ctrl.sv
// Frequency source selection, watchdog and system reset pulse generation.
// Assumes the SMBus register file sits outside and presents plain bits;
// write strobes are one-cycle pulses on the cycle a field is updated.
`timescale 1ns/1ps
// Overview of operation
// - Non-programmable mode uses strap code, or soft code when override set.
// - Programmable mode outputs N, M and gear constant for the PLL.
// - Writing N or M in programmable mode starts a frequency load.
// - Programmable mode ratio and gear from straps or soft code by override.
// - Time-out switches to recovery frequency, strap or recovery N/M.
// - Recovery ratio: strap code on strap recovery; on recovery N/M, strap or soft code by override.
// - Updating recovery N or M while running on recovery N/M starts a frequency load.
// - Watchdog held reloaded when disabled; counts after frequency change.
// - Time-out flag reads 1 after time-out; writing 1 clears it.
// - Watchdog counts down stored 5-bit value, flags at zero.
// - Prescaler selects 150 ms or 2.5 sec steps.
// - Reset pulse on time-out when reset_on_timeout is set.
// - Reset pulse after frequency change when reset_on_freq_change set.
// - N/M span supports 50 MHz to 248 MHz outputs.
// - After reset, programmable mode off and override zero.
// - Fcpu = G*(N+3)/(M+3); host keeps N+3 above M+3.
module pfwr_ctrl
#(
  parameter longint SHORT_CYC = pfwr_pkg::TICK_SHORT_CYC,
  parameter longint LONG_CYC  = pfwr_pkg::TICK_LONG_CYC,
  parameter int     PULSE_CYC = pfwr_pkg::RST_PULSE_CYC
)
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Strap capture
  input  wire logic [pfwr_pkg::CODE_W-1:0] strap_pins,
  input  wire logic                        strap_latch,
  // Frequency control bits
  input  wire logic                        prog_freq_enable,
  input  wire logic                        strap_override,
  input  wire logic [pfwr_pkg::CODE_W-1:0] soft_freq_code,
  input  wire pfwr_pkg::pfwr_nm_t          cpu_nm,
  input  wire logic                        cpu_nm_write,
  input  wire logic                        recovery_source_select,
  input  wire pfwr_pkg::pfwr_nm_t          recovery_nm,
  input  wire logic                        recovery_nm_write,
  // Watchdog control bits
  input  wire logic                        watchdog_enable,
  input  wire logic [pfwr_pkg::WD_W-1:0]   timeout_count,
  input  wire logic                        timeout_tick_scale,
  input  wire logic                        timeout_flag_clear,
  input  wire logic                        reset_on_timeout,
  input  wire logic                        reset_on_freq_change,
  // Status and outputs
  output logic [pfwr_pkg::CODE_W-1:0]      strap_freq_code,
  output logic                             timeout_flag,
  output pfwr_pkg::pfwr_freq_t             freq_sel,
  output logic                             freq_load,
  output logic                             sys_reset
);
  import pfwr_pkg::*;

  // ==========================================================================
  // Registers
  logic [CODE_W-1:0] strap_reg;
  logic              recov_reg;
  logic              flag_reg;
  logic              flag_next;
  pfwr_wd_t          wd_reg;
  pfwr_wd_t          wd_next;
  logic [WD_W-1:0]   wd_cnt_reg;
  logic [WD_W-1:0]   wd_cnt_next;
  pfwr_freq_t        freq_reg;
  pfwr_freq_t        freq_next;
  logic              load_reg;
  logic [7:0]        pulse_reg;
  logic [7:0]        pulse_next;
  logic              sys_reset_reg;
  logic              tick;

  // ==========================================================================
  // Source selection
  wire [CODE_W-1:0] ratio_code = strap_override ? soft_freq_code
                                                : strap_reg;
  wire pfwr_src_t   base_src   = strap_override ? PFWR_SRC_SOFT
                                                : PFWR_SRC_STRAP;
  // Stored value k trips on tick k+1, so 0..31 spans 1..32 steps
  wire              timeout    = (wd_reg == PFWR_WD_RUN) && tick &&
                                 (wd_cnt_reg == '0);
  wire              recov_now  = recov_reg || timeout;
  wire              load_cpu   = prog_freq_enable && cpu_nm_write;
  wire              load_rec   = recov_reg && recovery_source_select &&
                                 recovery_nm_write;
  wire              freq_change = (freq_next != freq_reg) || load_cpu ||
                                  load_rec;

  // Frequency word: recovery wins, then programmable, then code select
  always_comb
  begin
    freq_next            = freq_reg;
    freq_next.ratio_code = ratio_code;
    freq_next.recovery   = recov_now;
    if (recov_now && recovery_source_select)
    begin
      freq_next.src = PFWR_SRC_NM;
      freq_next.nm  = recovery_nm;
    end
    else if (recov_now)
    begin
      freq_next.src        = PFWR_SRC_STRAP;
      freq_next.ratio_code = strap_reg;
    end
    else if (prog_freq_enable)
    begin
      freq_next.src = PFWR_SRC_NM;
      freq_next.nm  = cpu_nm;
    end
    else
    begin
      freq_next.src = base_src;
    end
  end

  // ==========================================================================
  // Watchdog
  pfwr_tick #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_tick (
    .clk        (clk),
    .rst        (rst),
    .restart    (wd_reg != PFWR_WD_RUN),
    .long_scale (timeout_tick_scale),
    .tick       (tick)
  );

  // Idle until a change, run down, then stay tripped until re-armed
  always_comb
  begin
    wd_next     = wd_reg;
    wd_cnt_next = wd_cnt_reg;
    unique case (wd_reg)
      PFWR_WD_IDLE:
      begin
        wd_cnt_next = timeout_count;
        if (freq_change)
          wd_next = PFWR_WD_RUN;
      end
      PFWR_WD_RUN:
      begin
        if (timeout)
          wd_next = PFWR_WD_TRIP;
        else if (tick)
          wd_cnt_next = wd_cnt_reg - 1'b1;
      end
      PFWR_WD_TRIP:
        wd_cnt_next = '0;
      default:
        wd_next = PFWR_WD_IDLE;
    endcase
    if (!watchdog_enable)
    begin
      wd_next     = PFWR_WD_IDLE;
      wd_cnt_next = timeout_count;
    end
  end

  // Set beats a same-cycle clear so no time-out is lost
  assign flag_next = timeout || (flag_reg && !timeout_flag_clear);

  // Pulse timer reloads on each triggering event
  always_comb
  begin
    pulse_next = (pulse_reg != 8'h00) ? pulse_reg - 8'h01 : 8'h00;
    if ((timeout && reset_on_timeout) ||
        (freq_change && reset_on_freq_change))
      pulse_next = 8'(PULSE_CYC);
  end

  // ==========================================================================
  // State update; defaults give strap-driven frequency out of reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_reg  <= CODE_RST;
      recov_reg  <= 1'b0;
      flag_reg   <= 1'b0;
      wd_reg     <= PFWR_WD_IDLE;
      wd_cnt_reg <= '0;
      freq_reg   <= '{PFWR_SRC_STRAP, CODE_RST, '{N_RST, M_RST}, 1'b0};
      load_reg   <= 1'b0;
      pulse_reg  <= 8'h00;
      sys_reset_reg <= 1'b0;
    end
    else
    begin
      if (strap_latch)
        strap_reg <= strap_pins;
      recov_reg  <= recov_now && watchdog_enable;
      flag_reg   <= flag_next;
      wd_reg     <= wd_next;
      wd_cnt_reg <= wd_cnt_next;
      freq_reg   <= freq_next;
      load_reg   <= freq_change;
      pulse_reg  <= pulse_next;
      // Registered copy of the pulse level keeps the pin glitch free
      sys_reset_reg <= (pulse_next != 8'h00);
    end
  end

  // Outputs come straight from flip-flops
  assign strap_freq_code = strap_reg;
  assign timeout_flag    = flag_reg;
  assign freq_sel        = freq_reg;
  assign freq_load       = load_reg;
  assign sys_reset       = sys_reset_reg;

  // ==========================================================================
  // Assertions
  sequence s_trip;
    timeout;
  endsequence

  a_flag_sets: assert property (@(posedge clk) disable iff (rst)
    s_trip |=> timeout_flag)
    else $error("timeout flag not set");
  a_flag_clears: assert property (@(posedge clk) disable iff (rst)
    timeout_flag && timeout_flag_clear && !timeout |=> !timeout_flag)
    else $error("timeout flag not cleared");
  a_recov_switch: assert property (@(posedge clk) disable iff (rst)
    s_trip ##0 recovery_source_select |=> freq_sel.src == PFWR_SRC_NM
    && freq_sel.nm == $past(recovery_nm))
    else $error("recovery N/M not applied");
  a_strap_mode: assert property (@(posedge clk) disable iff (rst)
    !prog_freq_enable && !recov_now && !strap_override
    |=> freq_sel.src == PFWR_SRC_STRAP)
    else $error("strap source not chosen");
  a_prog_nm: assert property (@(posedge clk) disable iff (rst)
    prog_freq_enable && !recov_now |=> freq_sel.src == PFWR_SRC_NM
    && freq_sel.nm == $past(cpu_nm))
    else $error("programmed N/M not applied");
  a_load_write: assert property (@(posedge clk) disable iff (rst)
    load_cpu |=> freq_load)
    else $error("no load on N/M write");
  a_wd_hold: assert property (@(posedge clk) disable iff (rst)
    !watchdog_enable |=> wd_reg == PFWR_WD_IDLE && !recov_reg)
    else $error("watchdog not held");
  a_rst_timeout: assert property (@(posedge clk) disable iff (rst)
    timeout && reset_on_timeout |=> sys_reset [*8])
    else $error("reset pulse missing");
  a_no_rst: assert property (@(posedge clk) disable iff (rst)
    !sys_reset && !(timeout && reset_on_timeout)
    && !(freq_change && reset_on_freq_change) |=> !sys_reset)
    else $error("spurious reset pulse");

endmodule

// ===== tb/pfwr_host_model.sv
// Partner model: SMBus host writing N/M pairs and clearing the flag.
// Assumes the bench calls its tasks; changes land 1 ns after clk.
`timescale 1ns/1ps
module pfwr_host_model
(
  // Clock
  input  wire logic          clk,
  // Register writes toward the block
  output pfwr_pkg::pfwr_nm_t cpu_nm,
  output logic               cpu_nm_write,
  output pfwr_pkg::pfwr_nm_t recovery_nm,
  output logic               recovery_nm_write,
  output logic               timeout_flag_clear
);
  import pfwr_pkg::*;

  // ==========================================================================
  // Idle host: nothing written yet
  initial
  begin
    cpu_nm = '0;
    cpu_nm_write = 1'b0;
    recovery_nm = '0;
    recovery_nm_write = 1'b0;
    timeout_flag_clear = 1'b0;
  end

  // Word write: both halves move in one cycle, never a half pair
  // Callers keep N+3 above M+3
  task automatic write_pair(input logic rec, input pfwr_nm_t v);
    begin
      @(posedge clk);
      #1;
      recovery_nm = rec ? v : recovery_nm;
      cpu_nm = rec ? cpu_nm : v;
      recovery_nm_write = rec;
      cpu_nm_write = !rec;
      @(posedge clk);
      #1;
      recovery_nm_write = 1'b0;
      cpu_nm_write = 1'b0;
    end
  endtask

  // Writing 1 to the status bit clears it
  task automatic clear_flag();
    begin
      @(posedge clk);
      #1;
      timeout_flag_clear = 1'b1;
      @(posedge clk);
      #1;
      timeout_flag_clear = 1'b0;
    end
  endtask
endmodule

// ===== tb/prog_freq_watchdog_recovery_tb.sv
// Self-checking bench for the frequency select and watchdog block.
// Assumes short tick parameters so a time-out takes tens of cycles.
`timescale 1ns/1ps
module prog_freq_watchdog_recovery_tb;
  import pfwr_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk, rst, strap_latch, prog_freq_enable, strap_override;
  logic [4:0]  strap_pins, soft_freq_code, timeout_count, strap_freq_code;
  pfwr_nm_t    cpu_nm, recovery_nm;
  logic        cpu_nm_write, recovery_nm_write, recovery_source_select;
  logic        watchdog_enable, timeout_tick_scale, timeout_flag_clear;
  logic        reset_on_timeout, reset_on_freq_change, timeout_flag;
  logic        freq_load, sys_reset;
  pfwr_freq_t  freq_sel;
  int          n_errors = 0;
  int          comparisons = 0;

  // Short ticks keep the run brief; expectations derive from these
  localparam int SIM_SHORT = 10;
  localparam int SIM_LONG  = 20;
  localparam int SIM_PULSE = 16;

  pfwr_ctrl #(
    .SHORT_CYC (SIM_SHORT),
    .LONG_CYC  (SIM_LONG),
    .PULSE_CYC (SIM_PULSE)
  ) dut_u (
    .clk                    (clk),
    .rst                    (rst),
    .strap_pins             (strap_pins),
    .strap_latch            (strap_latch),
    .prog_freq_enable       (prog_freq_enable),
    .strap_override         (strap_override),
    .soft_freq_code         (soft_freq_code),
    .cpu_nm                 (cpu_nm),
    .cpu_nm_write           (cpu_nm_write),
    .recovery_source_select (recovery_source_select),
    .recovery_nm            (recovery_nm),
    .recovery_nm_write      (recovery_nm_write),
    .watchdog_enable        (watchdog_enable),
    .timeout_count          (timeout_count),
    .timeout_tick_scale     (timeout_tick_scale),
    .timeout_flag_clear     (timeout_flag_clear),
    .reset_on_timeout       (reset_on_timeout),
    .reset_on_freq_change   (reset_on_freq_change),
    .strap_freq_code        (strap_freq_code),
    .timeout_flag           (timeout_flag),
    .freq_sel               (freq_sel),
    .freq_load              (freq_load),
    .sys_reset              (sys_reset)
  );

  pfwr_host_model host_u (
    .clk                (clk),
    .cpu_nm             (cpu_nm),
    .cpu_nm_write       (cpu_nm_write),
    .recovery_nm        (recovery_nm),
    .recovery_nm_write  (recovery_nm_write),
    .timeout_flag_clear (timeout_flag_clear)
  );

  always #50 clk = ~clk;

  // ==========================================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for a level; a miss shows up as a mismatch
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim)
    begin
      step(1);
      k++;
    end
    chk(s, 1'b1);
  endtask

  task automatic pulse_len(input int exp);
    int k;
    k = 0;
    while (sys_reset === 1'b1 && k < 40)
    begin
      step(1);
      k++;
    end
    chk(k, exp);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_strap();
    strap_latch = 1'b0;
    strap_pins = 5'h0C;
    step(2);
    chk(strap_freq_code, 5'h13);
    chk(freq_sel.src, PFWR_SRC_STRAP);
    chk(freq_sel.ratio_code, 5'h13);
    strap_override = 1'b1;
    step(3);
    chk(freq_sel.src, PFWR_SRC_SOFT);
    chk(freq_sel.ratio_code, 5'h1E);
  endtask

  task automatic t_prog();
    strap_override = 1'b0;
    prog_freq_enable = 1'b1;
    host_u.write_pair(1'b0, '{8'h7F, 7'h30});
    wait_hi(freq_load, 4);
    step(1);
    chk(freq_sel.src, PFWR_SRC_NM);
    chk(freq_sel.nm, 15'h3FB0);
    chk(freq_sel.ratio_code, 5'h13);
    strap_override = 1'b1;
    step(3);
    chk(freq_sel.ratio_code, 5'h1E);
    // Same pair again: only the write itself can raise the load
    chk(freq_load, 1'b0);
    host_u.write_pair(1'b0, '{8'h7F, 7'h30});
    chk(freq_load, 1'b1);
  endtask

  task automatic t_freq_reset();
    reset_on_freq_change = 1'b1;
    host_u.write_pair(1'b0, '{8'h90, 7'h30});
    wait_hi(sys_reset, 3);
    pulse_len(SIM_PULSE);
    reset_on_freq_change = 1'b0;
    host_u.write_pair(1'b0, '{8'h91, 7'h30});
    step(3);
    chk(sys_reset, 1'b0);
    step(40);
    chk(timeout_flag, 1'b0);
  endtask

  // Arm by a frequency change; stored count k trips after k+1 ticks
  task automatic t_watchdog(input logic scale, input logic [4:0] cnt,
                            input logic sel);
    int tk;
    tk = scale ? SIM_LONG : SIM_SHORT;
    timeout_tick_scale = scale;
    timeout_count = cnt;
    recovery_source_select = sel;
    reset_on_timeout = sel;
    watchdog_enable = 1'b1;
    host_u.write_pair(1'b1, '{8'hA0, 7'h30});
    host_u.write_pair(1'b0, '{8'h92, 7'h30});
    step((cnt + 1) * tk - 1);
    chk(timeout_flag, 1'b0);
    wait_hi(timeout_flag, 2);
    chk(freq_sel.recovery, 1'b1);
    if (sel)
    begin
      chk(freq_sel.src, PFWR_SRC_NM);
      chk(freq_sel.nm, 15'h5030);
      chk(freq_sel.ratio_code, 5'h1E);
      wait_hi(sys_reset, 2);
      pulse_len(SIM_PULSE);
      host_u.write_pair(1'b1, '{8'hC0, 7'h30});
      wait_hi(freq_load, 4);
      step(1);
      chk(freq_sel.nm, 15'h6030);
    end
    else
    begin
      chk(freq_sel.src, PFWR_SRC_STRAP);
      chk(freq_sel.ratio_code, 5'h13);
      step(2);
      chk(sys_reset, 1'b0);
    end
    watchdog_enable = 1'b0;
    step(2);
    chk(timeout_flag, 1'b1);
    host_u.clear_flag();
    chk(timeout_flag, 1'b0);
  endtask

  // ==========================================================================
  // Main sequence: levels at time zero, reset for 8 cycles
  initial
  begin
    {recovery_source_select, watchdog_enable, timeout_tick_scale} = 3'h0;
    {reset_on_timeout, reset_on_freq_change} = 2'h0;
    rst = 1'b1;
    strap_latch = 1'b1;
    strap_pins = 5'h13;
    soft_freq_code = 5'h1E;
    timeout_count = 5'h00;
    strap_override = 1'b0;
    prog_freq_enable = 1'b0;
    clk = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    step(1);
    t_strap();
    t_prog();
    t_freq_reset();
    t_watchdog(1'b0, 5'h03, 1'b1);
    t_watchdog(1'b1, 5'h02, 1'b0);
    tally_and_finish();
  end

  // Watchdog on the run itself; the whole sequence needs well under this
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
